// ==== rtl/l2_port_pkg.sv ====
`default_nettype none
package l2_port_pkg;
  // register byte offsets
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] CMD_OFS    = 8'h04;
  localparam logic [7:0] STAT_OFS   = 8'h08;
  localparam logic [7:0] BYTE_OFS   = 8'h0C;
  // configuration fields
  localparam int CFG_ASYNC_BIT    = 0;
  localparam int CFG_ONCHIP_BIT   = 1;
  localparam int CFG_CPU2_BIT     = 2;
  localparam int CFG_HIT_POL_BIT  = 3;
  localparam int CFG_DIN_POL_BIT  = 4;
  localparam int CFG_DOUT_POL_BIT = 5;
  localparam int CFG_TV_POL_BIT   = 6;
  localparam logic [6:0] CFG_RST  = 7'h00;
  // command fields
  localparam int CMD_STROBE_BIT   = 0;
  localparam int CMD_ADVANCE_BIT  = 1;
  localparam int CMD_LATCH_BIT    = 2;
  localparam int CMD_LATCH_OE_BIT = 3;
  localparam int CMD_TAG_OE_BIT   = 4;
  localparam int CMD_TAG_WE_BIT   = 5;
  localparam int CMD_DIRTY_BIT    = 6;
  localparam int CMD_VALID_BIT    = 7;
  localparam int CMD_DOE_BIT      = 8;
  localparam int CMD_DWE_BIT      = 9;
  localparam int CMD_BA_LSB_BIT   = 10;
  localparam int CMD_BA_MSB_BIT   = 11;
  localparam int CMD_CPU1_BUS_BIT = 12;
  localparam int CMD_DGRANT_BIT   = 13;
  localparam logic [13:0] CMD_RST = 14'h0000;
  localparam logic [7:0]  BYTE_RST = 8'h00;
  // status fields
  localparam int STAT_HIT_BIT   = 0;
  localparam int STAT_DIRTY_BIT = 1;
  localparam int STAT_REQ_BIT   = 2;
  localparam int STAT_AGNT_BIT  = 3;
  localparam int STAT_DGNT_BIT  = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== rtl/l2_cache_and_second_cpu_pins.sv ====
// Operation
// - strobe pin: burst address strobe or async latch enable
// - advance pin: burst advance or burst address lsb
// - latch pin: latch transparent or burst address msb
// - line modified input decoded through programmable polarity
// - mark modified output driven at programmable polarity
// - data ram output enable only when rams drive data bus
// - hit input decoded through programmable polarity
// - latch drive enable for tag lookup and tag write
// - tag ram output enable in cache mode
// - tag write enable when tag, valid, dirty rewritten
// - tag valid output at programmable polarity
// - external byte decode: only second write enable pin used
// - on-chip decode: eight per-lane write enables
// - sram type and decode setting change shared pin meaning
// - second cpu mode reassigns three pins to request and grants
// - address grant lets second cpu start a transaction
// - data grant lets second cpu take the data bus
// - lane 0 is most significant byte, lane 7 least
`default_nettype none
module l2_cache_and_second_cpu_pins
  import l2_port_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // axi4-lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // external pins
  input  wire logic        i_hit,
  input  wire logic        i_dirty_in_req,
  output logic             o_strobe,
  output logic             o_advance,
  output logic             o_latch,
  output logic             o_tag_latch_drive_en,
  output logic             o_tag_oe_dgrant,
  output logic             o_dirty_out_agrant,
  output logic             o_tag_ram_write_en,
  output logic             o_tag_valid_out,
  output logic             o_data_ram_out_en,
  output logic [7:0]       o_data_ram_byte_we
);

  // register file
  logic [6:0]  cfg_q;
  logic [6:0]  cfg_d;
  logic [13:0] cmd_q;
  logic [13:0] cmd_d;
  logic [7:0]  lanes_q;
  logic [7:0]  lanes_d;
  logic [4:0]  stat_q;
  logic [4:0]  stat_d;
  // bus handshake state
  logic        aw_q;
  logic        aw_d;
  logic        w_q;
  logic        w_d;
  logic        b_q;
  logic        b_d;
  logic        r_q;
  logic        r_d;
  logic [7:0]  awa_q;
  logic [7:0]  awa_d;
  logic [31:0] wd_q;
  logic [31:0] wd_d;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [1:0]  bresp_q;
  logic [1:0]  bresp_d;
  logic [1:0]  rresp_q;
  logic [1:0]  rresp_d;
  // pin registers
  logic [8:0]  pins_q;
  logic [8:0]  pins_d;
  logic [7:0]  we_q;
  logic [7:0]  we_d;
  // input synchronisers
  logic        hit_meta_q;
  logic        hit_sync_q;
  logic        din_meta_q;
  logic        din_sync_q;
  // decoded controls
  logic        async_m;
  logic        onchip;
  logic        cpu2;
  logic        hit_dec;
  logic        dirty_dec;
  logic        req;
  logic        agrant;
  logic        dgrant;
  logic        commit;

  function automatic logic ofs_ok(input logic [7:0] a);
    return (a == CFG_OFS) || (a == CMD_OFS) || (a == STAT_OFS) ||
           (a == BYTE_OFS);
  endfunction

  // two-flop synchronisers for pin inputs
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      hit_meta_q <= 1'b0;
      hit_sync_q <= 1'b0;
      din_meta_q <= 1'b0;
      din_sync_q <= 1'b0;
    end else begin
      hit_meta_q <= i_hit;
      hit_sync_q <= hit_meta_q;
      din_meta_q <= i_dirty_in_req;
      din_sync_q <= din_meta_q;
    end
  end

  // mode and polarity decode
  always_comb begin
    async_m   = cfg_q[CFG_ASYNC_BIT];
    onchip    = cfg_q[CFG_ONCHIP_BIT];
    cpu2      = cfg_q[CFG_CPU2_BIT];
    hit_dec   = hit_sync_q ^ cfg_q[CFG_HIT_POL_BIT];
    dirty_dec = din_sync_q ^ cfg_q[CFG_DIN_POL_BIT];
    req       = cpu2 & din_sync_q;
    // no address grant while primary owns bus
    agrant    = cpu2 & req & ~cmd_q[CMD_CPU1_BUS_BIT];
    // data grant yields to address grant
    dgrant    = cpu2 & ~agrant & ~cmd_q[CMD_CPU1_BUS_BIT] &
                cmd_q[CMD_DGRANT_BIT];
  end

  // pin drive
  always_comb begin
    pins_d = '0;
    we_d   = '0;
    pins_d[0] = cmd_q[CMD_STROBE_BIT];
    pins_d[1] = async_m ? cmd_q[CMD_BA_LSB_BIT] : cmd_q[CMD_ADVANCE_BIT];
    pins_d[2] = async_m ? cmd_q[CMD_BA_MSB_BIT] : cmd_q[CMD_LATCH_BIT];
    pins_d[3] = cmd_q[CMD_LATCH_OE_BIT] | cmd_q[CMD_TAG_OE_BIT] |
                cmd_q[CMD_TAG_WE_BIT];
    pins_d[4] = cpu2 ? dgrant : cmd_q[CMD_TAG_OE_BIT];
    pins_d[5] = cpu2 ? agrant
                     : (cmd_q[CMD_DIRTY_BIT] ^ cfg_q[CFG_DOUT_POL_BIT]);
    pins_d[6] = cmd_q[CMD_TAG_WE_BIT];
    pins_d[7] = cmd_q[CMD_VALID_BIT] ^ cfg_q[CFG_TV_POL_BIT];
    // data output enable, never with a write
    pins_d[8] = cmd_q[CMD_DOE_BIT] & ~cmd_q[CMD_DWE_BIT];
    if (cmd_q[CMD_DWE_BIT]) begin
      // per-lane enables, lane 0 at bit 7
      if (onchip) begin
        we_d = {lanes_q[0], lanes_q[1], lanes_q[2], lanes_q[3],
                lanes_q[4], lanes_q[5], lanes_q[6], lanes_q[7]};
      end else begin
        we_d[6] = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pins_q <= '0;
      we_q   <= '0;
    end else begin
      pins_q <= pins_d;
      we_q   <= we_d;
    end
  end

  // axi4-lite slave and register writes
  always_comb begin
    cfg_d   = cfg_q;
    cmd_d   = cmd_q;
    lanes_d = lanes_q;
    aw_d    = aw_q;
    w_d     = w_q;
    b_d     = b_q;
    r_d     = r_q;
    awa_d   = awa_q;
    wd_d    = wd_q;
    rd_d    = rd_q;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    commit  = aw_q && w_q && !b_q;
    stat_d = {dgrant, agrant, req, dirty_dec, hit_dec};
    if (i_awvalid && !aw_q) begin
      aw_d  = 1'b1;
      awa_d = i_awaddr;
    end
    if (i_wvalid && !w_q) begin
      w_d  = 1'b1;
      wd_d = i_wdata;
    end
    if (commit) begin
      aw_d    = 1'b0;
      w_d     = 1'b0;
      b_d     = 1'b1;
      bresp_d = ofs_ok(awa_q) ? RESP_OKAY : RESP_SLVERR;
      case (awa_q)
        CFG_OFS: begin
          cfg_d = wd_q[6:0];
        end
        CMD_OFS: begin
          cmd_d = wd_q[13:0];
        end
        BYTE_OFS: begin
          lanes_d = wd_q[7:0];
        end
        default: begin
        end
      endcase
    end
    if (b_q && i_bready) begin
      b_d = 1'b0;
    end
    if (i_arvalid && !r_q) begin
      r_d     = 1'b1;
      rresp_d = ofs_ok(i_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (i_araddr)
        CFG_OFS:  rd_d = {25'h0, cfg_q};
        CMD_OFS:  rd_d = {18'h0, cmd_q};
        STAT_OFS: rd_d = {27'h0, stat_q};
        BYTE_OFS: rd_d = {24'h0, lanes_q};
        default:  rd_d = 32'h0000_0000;
      endcase
    end else if (r_q && i_rready) begin
      r_d = 1'b0;
    end
  end

  // register and handshake state
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cfg_q   <= CFG_RST;
      cmd_q   <= CMD_RST;
      lanes_q <= BYTE_RST;
      stat_q  <= '0;
      aw_q    <= 1'b0;
      w_q     <= 1'b0;
      b_q     <= 1'b0;
      r_q     <= 1'b0;
      awa_q   <= '0;
      wd_q    <= '0;
      rd_q    <= '0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
    end else begin
      cfg_q   <= cfg_d;
      cmd_q   <= cmd_d;
      lanes_q <= lanes_d;
      stat_q  <= stat_d;
      aw_q    <= aw_d;
      w_q     <= w_d;
      b_q     <= b_d;
      r_q     <= r_d;
      awa_q   <= awa_d;
      wd_q    <= wd_d;
      rd_q    <= rd_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
    end
  end

  always_comb begin
    o_awready            = i_awvalid && !aw_q;
    o_wready             = i_wvalid && !w_q;
    o_arready            = i_arvalid && !r_q;
    o_bvalid             = b_q;
    o_bresp              = bresp_q;
    o_rvalid             = r_q;
    o_rresp              = rresp_q;
    o_rdata              = rd_q;
    o_strobe             = pins_q[0];
    o_advance            = pins_q[1];
    o_latch              = pins_q[2];
    o_tag_latch_drive_en = pins_q[3];
    o_tag_oe_dgrant      = pins_q[4];
    o_dirty_out_agrant   = pins_q[5];
    o_tag_ram_write_en   = pins_q[6];
    o_tag_valid_out      = pins_q[7];
    o_data_ram_out_en    = pins_q[8];
    o_data_ram_byte_we   = we_q;
  end

endmodule // l2_cache_and_second_cpu_pins
`default_nettype wire

// ==== dv/l2_far_side.sv ====
`default_nettype none
module l2_far_side (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_tag_oe,
  input  wire logic i_tag_we,
  input  wire logic i_valid,
  input  wire logic i_want,
  output logic      o_hit,
  output logic      o_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic val_q;
  logic hit_q;
  // tag ram drives stored valid onto hit when enabled, hit toggles otherwise
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      val_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      if (i_tag_we) val_q <= i_valid;
      hit_q <= i_tag_oe ? val_q : ~hit_q;
    end
  end
  assign o_hit = hit_q;
  assign o_req = i_want;
endmodule // l2_far_side
`default_nettype wire

// ==== dv/l2_cache_and_second_cpu_pins_assertions.sv ====
`default_nettype none
module l2_pins_chk
  import l2_port_pkg::*;
(
  input wire logic i_clk_sys, i_rst_n, i_awvalid, o_awready,
  input wire logic i_wvalid, o_wready, o_bvalid, i_bready,
  input wire logic [7:0] i_awaddr,
  input wire logic [31:0] i_wdata,
  input wire logic [1:0] o_bresp,
  input wire logic o_strobe, o_tag_ram_write_en, o_tag_valid_out,
  input wire logic o_data_ram_out_en, o_tag_oe_dgrant, o_dirty_out_agrant,
  input wire logic [7:0] o_data_ram_byte_we
);
  logic [7:0] wa_q;
  logic [31:0] wd_q;
  logic [6:0] cfg_q;
  logic [13:0] cmd_q;
  logic [1:0] st_q;
  logic ok;
  logic wok;
  assign wok = o_bvalid && i_bready && o_bresp == RESP_OKAY;
  assign ok = st_q == 2'h3;
  // shadow of settled register contents
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      cfg_q <= CFG_RST;
      cmd_q <= CMD_RST;
      st_q <= 2'h0;
    end else begin
      if (i_awvalid && o_awready) wa_q <= i_awaddr;
      if (i_wvalid && o_wready) wd_q <= i_wdata;
      st_q <= (o_bvalid && i_bready) ? 2'h0 : (ok ? st_q : st_q + 2'h1);
      if (wok && wa_q == CFG_OFS) cfg_q <= wd_q[6:0];
      if (wok && wa_q == CMD_OFS) cmd_q <= wd_q[13:0];
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_strobe; ok |-> o_strobe == cmd_q[CMD_STROBE_BIT]; endproperty
  a_strobe: assert property (p_strobe) else $error("strobe pin wrong");
  property p_doe; ok && !cmd_q[CMD_DOE_BIT] |-> !o_data_ram_out_en; endproperty
  a_doe: assert property (p_doe) else $error("data oe unasked");
  property p_twe; ok |-> o_tag_ram_write_en == cmd_q[CMD_TAG_WE_BIT];
  endproperty
  a_twe: assert property (p_twe) else $error("tag we wrong");
  property p_tv;
    ok |-> o_tag_valid_out == (cmd_q[CMD_VALID_BIT] ^ cfg_q[CFG_TV_POL_BIT]);
  endproperty
  a_tv: assert property (p_tv) else $error("tag valid wrong");
  property p_ext;
    ok && !cfg_q[CFG_ONCHIP_BIT] |-> (o_data_ram_byte_we & 8'hbf) == 8'h00;
  endproperty
  a_ext: assert property (p_ext) else $error("extra write enable");
  property p_dwe;
    ok && !cfg_q[CFG_ONCHIP_BIT] |->
      o_data_ram_byte_we[6] == cmd_q[CMD_DWE_BIT];
  endproperty
  a_dwe: assert property (p_dwe) else $error("write enable wrong");
  property p_excl; ok && cfg_q[CFG_CPU2_BIT]
    |-> !(o_dirty_out_agrant && o_tag_oe_dgrant); endproperty
  a_excl: assert property (p_excl) else $error("both grants");
  property p_prim; ok && cfg_q[CFG_CPU2_BIT] && cmd_q[CMD_CPU1_BUS_BIT]
    |-> !o_dirty_out_agrant; endproperty
  a_prim: assert property (p_prim) else $error("grant while owned");
endmodule // l2_pins_chk
bind l2_cache_and_second_cpu_pins l2_pins_chk l2_pins_chk_i (.i_clk_sys,
  .i_rst_n, .i_awvalid, .o_awready, .i_wvalid, .o_wready, .o_bvalid,
  .i_bready, .i_awaddr, .i_wdata, .o_bresp, .o_strobe, .o_tag_ram_write_en,
  .o_tag_valid_out, .o_data_ram_out_en, .o_tag_oe_dgrant,
  .o_dirty_out_agrant, .o_data_ram_byte_we);
`default_nettype wire

// ==== dv/l2_cache_and_second_cpu_pins_tb.sv ====
`default_nettype none
module l2_cache_and_second_cpu_pins_tb
  import l2_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0;
  logic i_bready = 0, i_arvalid = 0, i_rready = 0, want = 0;
  logic [7:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, o_rdata, d;
  logic [3:0] i_wstrb = 4'hf;
  logic [1:0] o_bresp, o_rresp;
  logic [7:0] o_data_ram_byte_we;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_hit;
  logic i_dirty_in_req, o_strobe, o_advance, o_latch, o_tag_latch_drive_en;
  logic o_tag_oe_dgrant, o_dirty_out_agrant, o_tag_ram_write_en;
  logic o_tag_valid_out, o_data_ram_out_en;
  int fail_count = 0, n_checks = 0;
  always #25 i_clk_sys = ~i_clk_sys;
  l2_cache_and_second_cpu_pins l2_cache_and_second_cpu_pins_i (.*);
  l2_far_side l2_far_side_i (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_tag_oe(o_tag_oe_dgrant), .i_tag_we(o_tag_ram_write_en),
    .i_valid(o_tag_valid_out), .i_want(want), .o_hit(i_hit),
    .o_req(i_dirty_in_req));
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] er = RESP_OKAY);
    logic ta, tw, t;
    logic [1:0] r;
    @(posedge i_clk_sys);
    {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, v, 3'h7};
    forever begin
      @(negedge i_clk_sys);
      {ta, tw, t, r} = {i_awvalid & o_awready, i_wvalid & o_wready,
                        o_bvalid, o_bresp};
      @(posedge i_clk_sys);
      if (ta) i_awvalid <= 0;
      if (tw) i_wvalid <= 0;
      if (t) i_bready <= 0;
      if (t) break;
    end
    chk("bresp", {t, r}, {1'b1, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er = RESP_OKAY);
    logic ta, t;
    logic [1:0] r;
    @(posedge i_clk_sys);
    {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
    forever begin
      @(negedge i_clk_sys);
      {ta, t, d, r} = {i_arvalid & o_arready, o_rvalid, o_rdata, o_rresp};
      @(posedge i_clk_sys);
      if (ta) i_arvalid <= 0;
      if (t) i_rready <= 0;
      if (t) break;
    end
    chk("rresp", {t, r}, {1'b1, er});
  endtask
  task automatic settle;
    repeat (6) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
  endtask
  task automatic t_regs;
    rd(CFG_OFS);
    chk("cfg", d, 32'h0000_0000);
    rd(8'h10, RESP_SLVERR);
    chk("unmapped", d, 32'h0000_0000);
    wr(8'h10, 32'h0000_0001, RESP_SLVERR);
  endtask
  task automatic t_modes;
    wr(CMD_OFS, 32'h0000_010f);
    settle();
    chk("adv", o_advance, 1);
    chk("tag_latch_transparent", o_latch, 1);
    chk("tag_latch_drive_en", o_tag_latch_drive_en, 1);
    chk("doe", o_data_ram_out_en, 1);
    wr(CFG_OFS, 32'h0000_0001);
    wr(CMD_OFS, 32'h0000_0c00);
    settle();
    chk("ba", {o_strobe, o_advance, o_latch}, 3'h3);
  endtask
  task automatic t_tag;
    wr(CFG_OFS, 32'h0000_0000);
    wr(CMD_OFS, 32'h0000_00e0);
    settle();
    chk("dout", o_dirty_out_agrant, 1);
    wr(CMD_OFS, 32'h0000_0018);
    settle();
    chk("toe", o_tag_oe_dgrant, 1);
    rd(STAT_OFS);
    chk("hit", d[STAT_HIT_BIT], 1);
    want <= 1;
    wr(CFG_OFS, 32'h0000_0078);
    wr(CMD_OFS, 32'h0000_00d8);
    settle();
    chk("dout_pol", o_dirty_out_agrant, 0);
    rd(STAT_OFS);
    chk("pol", d[1:0], 2'h0);
    want <= 0;
  endtask
  task automatic t_bytes;
    wr(CFG_OFS, 32'h0000_0002);
    wr(BYTE_OFS, 32'h0000_0001);
    wr(CMD_OFS, 32'h0000_0200);
    settle();
    chk("lanes", o_data_ram_byte_we, 8'h80);
    wr(CFG_OFS, 32'h0000_0000);
    settle();
    chk("dwe1", o_data_ram_byte_we, 8'h40);
  endtask
  task automatic t_cpu2;
    want <= 1;
    wr(CFG_OFS, 32'h0000_0004);
    wr(CMD_OFS, 32'h0000_0000);
    settle();
    chk("agnt", o_dirty_out_agrant, 1);
    rd(STAT_OFS);
    chk("req", d[STAT_REQ_BIT], 1);
    wr(CMD_OFS, 32'h0000_3000);
    settle();
    chk("owned", {o_dirty_out_agrant, o_tag_oe_dgrant}, 2'h0);
    want <= 0;
    wr(CMD_OFS, 32'h0000_2000);
    settle();
    chk("grants", {o_dirty_out_agrant, o_tag_oe_dgrant}, 2'h1);
    wr(CMD_OFS, 32'h0000_0000);
    settle();
    chk("idle", o_dirty_out_agrant, 0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1;
    t_regs();
    t_modes();
    t_tag();
    t_bytes();
    t_cpu2();
    end_of_test();
  end
  initial begin
    repeat (4000) @(posedge i_clk_sys);
    fail_count++;
    end_of_test();
  end
endmodule // l2_cache_and_second_cpu_pins_tb
`default_nettype wire
